// *** design/icf_pkg.sv ***
// Contract
// RQ1 - Byte 525 bit0 reports volatile cache present
// RQ2 - With cache, honour flush and cache feature
// RQ3 - Without cache, flush completes successfully, no action
// RQ4 - Without cache, cache feature gets invalid field
// RQ5 - Bytes 527:526 hold zero-based normal atomic unit
// RQ6 - Writes within atomic unit commit atomically
// RQ7 - All-ones normal unit means every command atomic
// RQ8 - Recommend normal unit of at least 128KB
// RQ9 - Bytes 529:528 hold zero-based power-fail unit
// RQ10 - Byte 530 bit0 flags standard vendor command layout
// RQ11 - Power state zero descriptor at 2079:2048
// RQ12 - Optional power state one descriptor at 2111:2080
// RQ13 - Reserved identify bits and bytes read zero
package icf_pkg;
  // Identify structure byte offsets
  localparam logic [12:0] OFS_CACHE = 13'h020D;
  localparam logic [12:0] OFS_AWN_LO = 13'h020E;
  localparam logic [12:0] OFS_AWN_HI = 13'h020F;
  localparam logic [12:0] OFS_AWP_LO = 13'h0210;
  localparam logic [12:0] OFS_AWP_HI = 13'h0211;
  localparam logic [12:0] OFS_VENDOR = 13'h0212;
  localparam logic [12:0] OFS_POWER_STATE_ZERO_DESCRIPTOR = 13'h0800;
  localparam logic [12:0] OFS_POWER_STATE_ONE_DESCRIPTOR = 13'h0820;
  localparam logic [12:0] PSD_BYTES = 13'h0020;
  // Block's own registers, above the identify image
  localparam logic [12:0] OFS_CTRL = 13'h1000;
  localparam logic [12:0] OFS_STATUS = 13'h1004;
  localparam int CTRL_CACHE_EN = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_LAST_LO = 8;
  // Command encodings
  localparam logic [7:0] OPC_FLUSH = 8'h00;
  localparam logic [7:0] OPC_WRITE = 8'h01;
  localparam logic [7:0] OPC_SET_FEATURES = 8'h09;
  localparam logic [7:0] FID_CACHE = 8'h06;
  localparam logic [7:0] ST_SUCCESS = 8'h00;
  localparam logic [7:0] ST_INVALID_OPCODE = 8'h01;
  localparam logic [7:0] ST_INVALID_FIELD = 8'h02;
  localparam logic [15:0] ATOMIC_ALL = 16'hFFFF;
  // Recommended normal unit: 128KB over 512-byte blocks, zero-based
  localparam logic [15:0] AWN_DEFAULT = 16'h00FF;
  localparam logic [15:0] AWP_DEFAULT = 16'h0000;
  typedef enum logic [0:0] {ICF_IDLE, ICF_FLUSH_WAIT} icf_state_t;
endpackage

// *** design/icf_identify_ctrl.sv ***
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module icf_identify_ctrl #(
  parameter bit CACHE_PRESENT = 1'b1,
  // Default follows the recommended 128KB unit for small blocks
  parameter logic [15:0] ATOMIC_NORMAL = icf_pkg::AWN_DEFAULT, // RQ8
  parameter logic [15:0] ATOMIC_POWER_FAIL = icf_pkg::AWP_DEFAULT,
  parameter bit VENDOR_STD_FORMAT = 1'b1,
  parameter logic [255:0] POWER_STATE_ZERO_DESCRIPTOR_VALUE = 256'h0,
  parameter bit POWER_STATE_ONE_DESCRIPTOR_PRESENT = 1'b0,
  parameter logic [255:0] POWER_STATE_ONE_DESCRIPTOR_VALUE = 256'h0
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [12:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_fid,
  input wire logic [31:0] cmd_value,
  input wire logic [15:0] cmd_nlb,
  output logic cmd_busy,
  output logic cpl_valid,
  output logic [7:0] cpl_status,
  output logic cpl_atomic,
  output logic cpl_atomic_pf,
  output logic flush_req,
  input wire logic flush_done,
  output logic cache_enable
);

  // Bus words are four bytes wide
  localparam int ICF_WORD_SHIFT = 2;
  localparam int ICF_LANE_BITS = 8;
  localparam int ICF_WORD_BITS = 32;

  // Word index of a byte offset in the identify image
  function automatic logic [10:0] icf_word(input logic [12:0] byte_ofs);
    logic [12:0] shifted;
    shifted = byte_ofs >> ICF_WORD_SHIFT;
    icf_word = shifted[10:0];
  endfunction

  // Bit position of a byte inside its bus word, little endian
  function automatic int icf_lane(input logic [12:0] byte_ofs);
    icf_lane = int'(byte_ofs[ICF_WORD_SHIFT-1:0]) * ICF_LANE_BITS;
  endfunction

  // Zero-based length against a zero-based unit; all ones covers every command
  function automatic logic icf_fits(input logic [15:0] nlb, input logic [15:0] unit);
    icf_fits = (unit == icf_pkg::ATOMIC_ALL) || (nlb <= unit); // RQ7
  endfunction

  // One word of a power state descriptor
  function automatic logic [31:0] icf_psd_word(input logic [255:0] value,
                                                input logic [2:0] idx);
    icf_psd_word = value[idx * ICF_WORD_BITS +: ICF_WORD_BITS];
  endfunction

  // Read path signals
  logic [10:0] rd_word;
  logic [31:0] next_rdata;
  logic [2:0] psd_idx;
  logic in_power_state_zero_descriptor;
  logic in_power_state_one_descriptor;

  // Command path signals
  icf_pkg::icf_state_t state;
  logic accept;
  logic [7:0] dec_status;
  logic dec_wait;
  logic dec_set_cache;

  assign rd_word = icf_word(addr);

  // Descriptor windows; each descriptor is eight bus words
  assign in_power_state_zero_descriptor = (rd_word >= icf_word(icf_pkg::OFS_POWER_STATE_ZERO_DESCRIPTOR)) &&
                   (rd_word < icf_word(icf_pkg::OFS_POWER_STATE_ZERO_DESCRIPTOR + icf_pkg::PSD_BYTES));
  assign in_power_state_one_descriptor = (rd_word >= icf_word(icf_pkg::OFS_POWER_STATE_ONE_DESCRIPTOR)) &&
                   (rd_word < icf_word(icf_pkg::OFS_POWER_STATE_ONE_DESCRIPTOR + icf_pkg::PSD_BYTES));
  assign psd_idx = rd_word[2:0]; // Descriptors start on a 32-byte boundary

  // Read mux; everything not named below reads as zero
  always_comb begin
    next_rdata = '0; // RQ13
    if (rd_word == icf_word(icf_pkg::OFS_CACHE)) begin
      // Byte below the cache byte belongs to an earlier field and reads zero here
      next_rdata[icf_lane(icf_pkg::OFS_CACHE) +: ICF_LANE_BITS] = {7'h00, CACHE_PRESENT}; // RQ1
      next_rdata[icf_lane(icf_pkg::OFS_AWN_LO) +: ICF_LANE_BITS] = ATOMIC_NORMAL[7:0]; // RQ5
      next_rdata[icf_lane(icf_pkg::OFS_AWN_HI) +: ICF_LANE_BITS] = ATOMIC_NORMAL[15:8]; // RQ5
    end else if (rd_word == icf_word(icf_pkg::OFS_AWP_LO)) begin
      next_rdata[icf_lane(icf_pkg::OFS_AWP_LO) +: ICF_LANE_BITS] = ATOMIC_POWER_FAIL[7:0]; // RQ9
      next_rdata[icf_lane(icf_pkg::OFS_AWP_HI) +: ICF_LANE_BITS] = ATOMIC_POWER_FAIL[15:8]; // RQ9
      next_rdata[icf_lane(icf_pkg::OFS_VENDOR) +: ICF_LANE_BITS] =
        {7'h00, VENDOR_STD_FORMAT}; // RQ10
    end else if (in_power_state_zero_descriptor) begin
      next_rdata = icf_psd_word(POWER_STATE_ZERO_DESCRIPTOR_VALUE, psd_idx); // RQ11
    end else if (in_power_state_one_descriptor) begin
      // Absent descriptor reads zero, like any reserved range
      next_rdata = POWER_STATE_ONE_DESCRIPTOR_PRESENT ? icf_psd_word(POWER_STATE_ONE_DESCRIPTOR_VALUE, psd_idx) : 32'h00000000; // RQ12
    end else if (addr == icf_pkg::OFS_CTRL) begin
      next_rdata[icf_pkg::CTRL_CACHE_EN] = cache_enable;
    end else if (addr == icf_pkg::OFS_STATUS) begin
      next_rdata[icf_pkg::STAT_BUSY] = cmd_busy;
      next_rdata[icf_pkg::STAT_LAST_LO +: ICF_LANE_BITS] = cpl_status;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= '0;
    end
  end

  // Commands offered while a flush drains are ignored; the host waits on busy
  assign accept = cmd_valid && (state == icf_pkg::ICF_IDLE);

  // Command decode: which status, and whether the cache must drain first
  always_comb begin
    dec_status = icf_pkg::ST_SUCCESS;
    dec_wait = 1'b0;
    dec_set_cache = 1'b0;
    unique case (cmd_opcode)
      icf_pkg::OPC_FLUSH: begin
        // Without a cache a flush has nothing to do and just succeeds
        dec_wait = CACHE_PRESENT; // RQ2 RQ3
      end
      icf_pkg::OPC_WRITE: begin
        dec_status = icf_pkg::ST_SUCCESS; // RQ6
      end
      icf_pkg::OPC_SET_FEATURES: begin
        if (cmd_fid != icf_pkg::FID_CACHE) begin
          dec_status = icf_pkg::ST_INVALID_FIELD;
        end else if (!CACHE_PRESENT) begin
          dec_status = icf_pkg::ST_INVALID_FIELD; // RQ4
        end else begin
          dec_set_cache = 1'b1; // RQ2
        end
      end
      default: begin
        dec_status = icf_pkg::ST_INVALID_OPCODE;
      end
    endcase
  end

  // Command state: idle, or waiting for the cache to drain
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state <= icf_pkg::ICF_IDLE;
    end else begin
      unique case (state)
        icf_pkg::ICF_IDLE: begin
          if (accept && dec_wait) begin
            state <= icf_pkg::ICF_FLUSH_WAIT; // RQ2
          end
        end
        icf_pkg::ICF_FLUSH_WAIT: begin
          if (flush_done) begin
            state <= icf_pkg::ICF_IDLE;
          end
        end
      endcase
    end
  end

  // Drain request to the cache, held until the cache answers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      flush_req <= 1'b0;
    end else if (accept && dec_wait) begin
      flush_req <= 1'b1; // RQ2
    end else if (flush_done) begin
      flush_req <= 1'b0;
    end
  end

  // Busy covers the whole drain so software can see it in status
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cmd_busy <= 1'b0;
    end else if (accept && dec_wait) begin
      cmd_busy <= 1'b1;
    end else if (flush_done) begin
      cmd_busy <= 1'b0;
    end
  end

  // Cache enable; a command wins over a register write in the same cycle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cache_enable <= 1'b0;
    end else if (!CACHE_PRESENT) begin
      cache_enable <= 1'b0; // RQ4
    end else if (accept && dec_set_cache) begin
      cache_enable <= cmd_value[0]; // RQ2
    end else if (wr && (addr == icf_pkg::OFS_CTRL)) begin
      cache_enable <= wdata[icf_pkg::CTRL_CACHE_EN];
    end
  end

  // Completion: a one-cycle pulse; status and atomic flags hold until the next one
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cpl_valid <= 1'b0;
      cpl_status <= icf_pkg::ST_SUCCESS;
      cpl_atomic <= 1'b0;
      cpl_atomic_pf <= 1'b0;
    end else begin
      cpl_valid <= 1'b0;
      if (accept && !dec_wait) begin
        cpl_valid <= 1'b1; // RQ3
        cpl_status <= dec_status; // RQ4
        // Media path commits a write flagged here as one unit
        cpl_atomic <= (cmd_opcode == icf_pkg::OPC_WRITE) &&
                      icf_fits(cmd_nlb, ATOMIC_NORMAL); // RQ6 RQ7
        cpl_atomic_pf <= (cmd_opcode == icf_pkg::OPC_WRITE) &&
                         icf_fits(cmd_nlb, ATOMIC_POWER_FAIL); // RQ9
      end else if ((state == icf_pkg::ICF_FLUSH_WAIT) && flush_done) begin
        cpl_valid <= 1'b1; // RQ2
        cpl_status <= icf_pkg::ST_SUCCESS;
        cpl_atomic <= 1'b0;
        cpl_atomic_pf <= 1'b0;
      end
    end
  end

  // A flush either drains the cache or completes at once with success
  property p_flush_path;
    @(posedge clock) disable iff (!nrst)
      (accept && (cmd_opcode == icf_pkg::OPC_FLUSH)) |=>
        (CACHE_PRESENT ? flush_req :
         (cpl_valid && (cpl_status == icf_pkg::ST_SUCCESS) && !flush_req));
  endproperty
  a_flush_path: assert property (p_flush_path) else $error("flush took the wrong path"); // RQ3

  // Cache feature answer depends only on whether a cache exists
  property p_cache_feature;
    @(posedge clock) disable iff (!nrst)
      (accept && (cmd_opcode == icf_pkg::OPC_SET_FEATURES) &&
       (cmd_fid == icf_pkg::FID_CACHE)) |=>
        (cpl_valid && (cpl_status == (CACHE_PRESENT ? icf_pkg::ST_SUCCESS :
                                                      icf_pkg::ST_INVALID_FIELD)));
  endproperty
  a_cache_feature: assert property (p_cache_feature) else $error("cache feature status"); // RQ4

  // Enable follows the value carried by an accepted cache feature command
  property p_cache_follow;
    @(posedge clock) disable iff (!nrst)
      (accept && dec_set_cache) |=> (cache_enable == $past(cmd_value[0]));
  endproperty
  a_cache_follow: assert property (p_cache_follow) else $error("cache enable not set"); // RQ2

  // The drain ends with a success completion and the request dropped
  property p_flush_end;
    @(posedge clock) disable iff (!nrst)
      ((state == icf_pkg::ICF_FLUSH_WAIT) && flush_done) |=>
        (cpl_valid && (cpl_status == icf_pkg::ST_SUCCESS) && !flush_req && !cmd_busy);
  endproperty
  a_flush_end: assert property (p_flush_end) else $error("flush did not complete"); // RQ2

  // A write within the normal unit is flagged atomic
  property p_write_atomic;
    @(posedge clock) disable iff (!nrst)
      (accept && (cmd_opcode == icf_pkg::OPC_WRITE) && (cmd_nlb <= ATOMIC_NORMAL)) |=>
        (cpl_valid && cpl_atomic);
  endproperty
  a_write_atomic: assert property (p_write_atomic) else $error("write not atomic"); // RQ6

  // Reserved words between the vendor byte and the descriptors read zero
  property p_reserved_zero;
    @(posedge clock) disable iff (!nrst)
      (rd && (rd_word > icf_word(icf_pkg::OFS_VENDOR)) &&
       (rd_word < icf_word(icf_pkg::OFS_POWER_STATE_ZERO_DESCRIPTOR))) |=> (rdata == 32'h00000000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved word not zero"); // RQ13

  // Cache presence bit reads back as built
  property p_cache_bit;
    @(posedge clock) disable iff (!nrst)
      (rd && (rd_word == icf_word(icf_pkg::OFS_CACHE))) |=>
        (rdata[icf_lane(icf_pkg::OFS_CACHE)] == CACHE_PRESENT);
  endproperty
  a_cache_bit: assert property (p_cache_bit) else $error("cache bit wrong"); // RQ1

  // Main scenarios reached
  c_flush_done: cover property (@(posedge clock) disable iff (!nrst)
    (state == icf_pkg::ICF_FLUSH_WAIT) && flush_done);
  c_set_cache: cover property (@(posedge clock) disable iff (!nrst)
    accept && dec_set_cache);
  c_write_big: cover property (@(posedge clock) disable iff (!nrst)
    accept && (cmd_opcode == icf_pkg::OPC_WRITE) && (cmd_nlb > ATOMIC_NORMAL));
  c_read_power_state_zero_descriptor: cover property (@(posedge clock) disable iff (!nrst) rd && in_power_state_zero_descriptor);

endmodule // icf_identify_ctrl

// *** tb/icf_cache_model.sv ***
`timescale 1ns/1ps
module icf_cache_model (
  input wire logic clock,
  input wire logic flush_req,
  output logic flush_done = 1'b0
);
  // Cache drains in one cycle; done is a pulse so a held request is not answered twice
  always_ff @(posedge clock) flush_done <= flush_req && !flush_done;
endmodule // icf_cache_model

// *** tb/icf_identify_ctrl_bench.sv ***
`timescale 1ns/1ps
module icf_identify_ctrl_bench;
  logic clock = 0, nrst = 0, wr = 0, rd = 0, cmd_valid = 0;
  logic flush_done, cmd_busy, cpl_valid, flush_req, cache_enable, cpl_atomic, cpl_atomic_pf;
  logic [12:0] addr = 13'h0;
  logic [31:0] wdata = 32'h0, rdata, cmd_value = 32'h1;
  logic [7:0] cmd_opcode = 8'h0, cmd_fid = 8'h0, cpl_status;
  logic [15:0] cmd_nlb = 16'h0;
  int err_total = 0, n_compared = 0;
  // Address beside expected word; byte 524 lies outside this block, so lane 0 is masked
  logic [44:0] rows [4] = '{{13'h20C, 32'h00FF0100}, {13'h210, 32'h10000},
    {13'h400, 32'h0}, {13'h800, 32'h0}};
  always #50 clock = ~clock;
  icf_identify_ctrl icf_identify_ctrl_inst (.clock, .nrst, .addr, .wdata, .wr, .rd, .rdata,
    .cmd_valid, .cmd_opcode, .cmd_fid, .cmd_value, .cmd_nlb, .cmd_busy, .cpl_valid, .cpl_status,
    .cpl_atomic, .cpl_atomic_pf, .flush_req, .flush_done, .cache_enable);
  icf_cache_model icf_cache_model_inst (.clock, .flush_req, .flush_done);
  task automatic c(string n, logic [31:0] e, s);
    n_compared++;
    if (s !== e) begin err_total++; $display("BAD %s exp %h got %h", n, e, s); end
  endtask
  task automatic end_sim;
    $display("compared %0d bad %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One command, then a bounded wait for its completion
  task automatic op(logic [7:0] o, f, e);
    @(posedge clock) {cmd_valid, cmd_opcode, cmd_fid} <= {1'b1, o, f};
    @(posedge clock) cmd_valid <= 1'b0;
    repeat (40) begin #1; if (cpl_valid === 1'b1) break; @(posedge clock); end
    c("cpl_valid", 32'h1, {31'h0, cpl_valid});
    c("status", e, cpl_status);
    $display("cmd %h done", o);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      @(posedge clock) {addr, rd} <= {rows[i][44:32], 1'b1};
      @(posedge clock) rd <= 1'b0;
      #1 c("rdata", rows[i][31:0], rdata & 32'hFFFFFF00);
    end
    $display("identify rows done");
    c("cache_enable", 32'h0, {31'h0, cache_enable});
    op(icf_pkg::OPC_FLUSH, 8'h0, icf_pkg::ST_SUCCESS);
    op(icf_pkg::OPC_SET_FEATURES, icf_pkg::FID_CACHE, icf_pkg::ST_SUCCESS);
    c("cache_enable", 32'h1, {31'h0, cache_enable});
    op(icf_pkg::OPC_SET_FEATURES, 8'h07, icf_pkg::ST_INVALID_FIELD);
    op(8'h7F, 8'h0, icf_pkg::ST_INVALID_OPCODE);
    // Writes at and just past the zero-based normal unit, and at and above the power-fail unit
    cmd_nlb <= icf_pkg::AWN_DEFAULT;
    op(icf_pkg::OPC_WRITE, 8'h0, icf_pkg::ST_SUCCESS);
    c("cpl_atomic", 32'h1, {31'h0, cpl_atomic});
    c("cpl_atomic_pf", 32'h0, {31'h0, cpl_atomic_pf});
    cmd_nlb <= icf_pkg::AWN_DEFAULT + 16'h0001;
    op(icf_pkg::OPC_WRITE, 8'h0, icf_pkg::ST_SUCCESS);
    c("cpl_atomic", 32'h0, {31'h0, cpl_atomic});
    cmd_nlb <= icf_pkg::AWP_DEFAULT;
    op(icf_pkg::OPC_WRITE, 8'h0, icf_pkg::ST_SUCCESS);
    c("cpl_atomic_pf", 32'h1, {31'h0, cpl_atomic_pf});
    // Register write of the enable, then read it back
    @(posedge clock) {addr, wdata, wr} <= {icf_pkg::OFS_CTRL, 32'h0, 1'b1};
    @(posedge clock) {wr, rd} <= 2'b01;
    @(posedge clock) rd <= 1'b0;
    #1 c("ctrl", 32'h0, rdata);
    $display("register test done");
    // Reset in mid-run clears the enable and the last status
    op(icf_pkg::OPC_SET_FEATURES, icf_pkg::FID_CACHE, icf_pkg::ST_SUCCESS);
    @(posedge clock) nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    #1 c("reset cache_enable", 32'h0, {31'h0, cache_enable});
    @(posedge clock) {addr, rd} <= {icf_pkg::OFS_STATUS, 1'b1};
    @(posedge clock) rd <= 1'b0;
    #1 c("status reg", 32'h0, rdata);
    $display("reset test done");
    end_sim;
  end
  // Watchdog well past the few dozen cycles the tests need
  initial begin #200000; err_total++; end_sim; end
endmodule // icf_identify_ctrl_bench
